// ---- lf_clock_pkg.sv ----
package lf_clock_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [7:0] SYNC_STATUS_OFFSET = 8'h50;
  localparam logic [7:0] FREEZE_OFFSET      = 8'h54;
  localparam logic [7:0] BRANCH_A_OFFSET    = 8'h58;
  localparam logic [7:0] BRANCH_B_OFFSET    = 8'h60;

  // Field positions.
  localparam int FREEZE_BIT      = 0;
  localparam int RTC_ENABLE_BIT  = 0;
  localparam int SERIAL0_BIT     = 0;
  localparam int BUSY_A_BIT      = 0;
  localparam int BUSY_B_BIT      = 4;

  // Reset values.
  localparam logic       FREEZE_RESET   = 1'h0;
  localparam logic       ENABLE_RESET   = 1'h0;
  localparam logic [31:0] READ_ZERO     = 32'h0;

  // Clock rates; the low-frequency domain is a tick every LF_DIVIDE reference cycles.
  localparam int REF_CLOCK_HZ = 200_000_000;
  localparam int LF_CLOCK_HZ  = 32_768;
  localparam int LF_DIVIDE    = REF_CLOCK_HZ / LF_CLOCK_HZ;

  typedef struct packed {
    logic freeze;
    logic branch_a;
    logic branch_b;
  } lf_ctrl_t;

endpackage

// ---- lf_tick_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
module lf_tick_divider #(
  parameter int DIVIDE = lf_clock_pkg::LF_DIVIDE
) (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Low-frequency enable pulse.
  output logic      lf_tick
);

  localparam int CW = (DIVIDE > 2) ? $clog2(DIVIDE) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

  generate
    if (DIVIDE < 2)
    begin : g_bad_divide
      $error("DIVIDE must be at least 2");
    end
  endgenerate

  logic [CW-1:0] count;
  wire           wrap = (count == LAST);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count   <= '0;
      lf_tick <= 1'b0;
    end
    else
    begin
      count   <= wrap ? '0 : count + 1'b1;
      lf_tick <= wrap;
    end
  end

endmodule
`default_nettype wire

// ---- lf_clock_gate_update_freeze.sv ----
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module lf_clock_gate_update_freeze #(
  parameter int LF_DIVIDE = lf_clock_pkg::LF_DIVIDE
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Avalon-MM slave.
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Low-frequency clock gates.
  output logic             rtc_clock_gate,
  output logic             low_energy_serial0_clock_gate
);

  logic                  lf_tick;
  lf_clock_pkg::lf_ctrl_t shadow;
  logic                  branch_a_enable_busy;
  logic                  branch_b_enable_busy;

  lf_tick_divider #(
    .DIVIDE (LF_DIVIDE)
  ) u_divider (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .lf_tick (lf_tick)
  );

  generate
    if (LF_DIVIDE < 2)
    begin : g_bad_lf_divide
      $error("LF_DIVIDE must be at least 2");
    end
  endgenerate

  // A request is answered with waitrequest low one cycle after it is seen.
  wire req        = read | write;
  wire accept     = req & ~waitrequest;
  wire byte0      = byteenable[0];
  wire hit_sync   = (address == lf_clock_pkg::SYNC_STATUS_OFFSET);
  wire hit_freeze = (address == lf_clock_pkg::FREEZE_OFFSET);
  wire hit_a      = (address == lf_clock_pkg::BRANCH_A_OFFSET);
  wire hit_b      = (address == lf_clock_pkg::BRANCH_B_OFFSET);

  wire wr_freeze  = accept & write & hit_freeze & byte0;
  wire wr_a       = accept & write & hit_a & byte0;
  wire wr_b       = accept & write & hit_b & byte0;

  // Transfers into the low-frequency domain happen only on a tick while not frozen.
  wire transfer   = lf_tick & ~shadow.freeze;
  wire apply_a    = transfer & branch_a_enable_busy;
  wire apply_b    = transfer & branch_b_enable_busy;

  function automatic logic [31:0] bit0_word(input logic value);
    bit0_word = lf_clock_pkg::READ_ZERO;
    bit0_word[lf_clock_pkg::RTC_ENABLE_BIT] = value;
  endfunction

  function automatic logic [31:0] sync_bits(input logic busy_a, input logic busy_b);
    sync_bits = lf_clock_pkg::READ_ZERO;
    sync_bits[lf_clock_pkg::BUSY_A_BIT] = busy_a;
    sync_bits[lf_clock_pkg::BUSY_B_BIT] = busy_b;
  endfunction

  wire [31:0] sync_word   = sync_bits(branch_a_enable_busy, branch_b_enable_busy);
  wire [31:0] freeze_word = bit0_word(shadow.freeze);
  wire [31:0] a_word      = bit0_word(shadow.branch_a);
  wire [31:0] b_word      = bit0_word(shadow.branch_b);
  wire [31:0] next_readdata = hit_sync   ? sync_word   :
                              hit_freeze ? freeze_word :
                              hit_a      ? a_word      :
                              hit_b      ? b_word      : lf_clock_pkg::READ_ZERO;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      waitrequest <= 1'b1;
      readdata    <= lf_clock_pkg::READ_ZERO;
    end
    else
    begin
      waitrequest <= ~(req & waitrequest);
      if (read & waitrequest)
        readdata <= next_readdata;
    end
  end

  // Bus-side copies of the control bits.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shadow.freeze   <= lf_clock_pkg::FREEZE_RESET;
      shadow.branch_a <= lf_clock_pkg::ENABLE_RESET;
      shadow.branch_b <= lf_clock_pkg::ENABLE_RESET;
    end
    else
    begin
      if (wr_freeze)
        shadow.freeze <= writedata[lf_clock_pkg::FREEZE_BIT];
      if (wr_a)
        shadow.branch_a <= writedata[lf_clock_pkg::RTC_ENABLE_BIT];
      if (wr_b)
        shadow.branch_b <= writedata[lf_clock_pkg::SERIAL0_BIT];
    end
  end

  // A new write sets busy even in the tick that would clear it.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      branch_a_enable_busy <= 1'b0;
      branch_b_enable_busy <= 1'b0;
    end
    else
    begin
      branch_a_enable_busy <= wr_a | (branch_a_enable_busy & ~apply_a);
      branch_b_enable_busy <= wr_b | (branch_b_enable_busy & ~apply_b);
    end
  end

  // Low-frequency domain state, updated only on a transfer tick.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rtc_clock_gate                <= lf_clock_pkg::ENABLE_RESET;
      low_energy_serial0_clock_gate <= lf_clock_pkg::ENABLE_RESET;
    end
    else
    begin
      if (apply_a)
        rtc_clock_gate <= shadow.branch_a;
      if (apply_b)
        low_energy_serial0_clock_gate <= shadow.branch_b;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  freeze_holds_gates_a: assert property (
    shadow.freeze |=> $stable(rtc_clock_gate) && $stable(low_energy_serial0_clock_gate))
    else $error("Gate changed while updates were frozen.");

  transfer_applies_a_a: assert property (
    lf_tick && !shadow.freeze && branch_a_enable_busy && !wr_a
      |=> !branch_a_enable_busy && rtc_clock_gate == $past(shadow.branch_a))
    else $error("Pending branch A value not applied on tick.");

  freeze_readback_a: assert property (
    read && !waitrequest && hit_freeze
      |-> readdata == {31'h0, shadow.freeze})
    else $error("Freeze register read returned a wrong value.");

  gate_a_timing_a: assert property (
    $changed(rtc_clock_gate) |-> $past(lf_tick) && !$past(shadow.freeze))
    else $error("Counter gate changed outside a transfer tick.");

  gate_b_timing_a: assert property (
    $changed(low_energy_serial0_clock_gate) |-> $past(lf_tick) && !$past(shadow.freeze))
    else $error("Serial gate changed outside a transfer tick.");

  busy_a_set_a: assert property (
    wr_a |=> branch_a_enable_busy)
    else $error("Branch A busy not raised after write.");

  busy_b_set_a: assert property (
    wr_b |=> branch_b_enable_busy)
    else $error("Branch B busy not raised after write.");

  frozen_keeps_busy_a: assert property (
    shadow.freeze && branch_a_enable_busy |=> branch_a_enable_busy)
    else $error("Branch A busy cleared while updates were frozen.");

  busy_a_read_a: assert property (
    read && !waitrequest && hit_sync
      |-> readdata[lf_clock_pkg::BUSY_A_BIT] == $past(branch_a_enable_busy))
    else $error("Sync status bit 0 does not show branch A busy.");

  busy_b_read_a: assert property (
    read && !waitrequest && hit_sync
      |-> readdata[lf_clock_pkg::BUSY_B_BIT] == $past(branch_b_enable_busy))
    else $error("Sync status bit 4 does not show branch B busy.");

  shadow_readback_a: assert property (
    read && !waitrequest && hit_a |-> readdata[0] == shadow.branch_a)
    else $error("Branch A read did not return the written value.");

  shadow_readback_b_a: assert property (
    read && !waitrequest && hit_b |-> readdata[lf_clock_pkg::SERIAL0_BIT] == shadow.branch_b)
    else $error("Branch B read did not return the written value.");

  transfer_applies_b_a: assert property (
    lf_tick && !shadow.freeze && branch_b_enable_busy && !wr_b
      |=> !branch_b_enable_busy && low_energy_serial0_clock_gate == $past(shadow.branch_b))
    else $error("Pending branch B value not applied on tick.");

  bus_answer_a: assert property (
    req && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("Bus answer not given one cycle after request.");

  frozen_batch_c: cover property (
    shadow.freeze && branch_a_enable_busy && branch_b_enable_busy ##1 !shadow.freeze);
  busy_read_c: cover property (
    read && !waitrequest && hit_sync && readdata[lf_clock_pkg::BUSY_A_BIT]);
  gate_on_c: cover property ($rose(low_energy_serial0_clock_gate));
  unfreeze_release_c: cover property ($fell(shadow.freeze) ##[1:8] $changed(rtc_clock_gate));
  gate_off_c: cover property ($fell(rtc_clock_gate));

endmodule
`default_nettype wire

// ---- test_lf_clock_gate_update_freeze.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_lf_clock_gate_update_freeze;
  localparam int DIV = 4;
  logic        ref_clk;
  logic        reset_n;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        rtc_clock_gate;
  logic        low_energy_serial0_clock_gate;
  int          fails;
  int          tests_run;
  logic [31:0] expq[$];
  logic [31:0] seed;

  lf_clock_gate_update_freeze #(.LF_DIVIDE(DIV)) u_dut (
    .ref_clk                       (ref_clk),
    .reset_n                       (reset_n),
    .address                       (address),
    .read                          (read),
    .write                         (write),
    .writedata                     (writedata),
    .byteenable                    (byteenable),
    .readdata                      (readdata),
    .waitrequest                   (waitrequest),
    .rtc_clock_gate                (rtc_clock_gate),
    .low_energy_serial0_clock_gate (low_energy_serial0_clock_gate)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One Avalon-MM access; a read notes its expected data for the watcher.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge ref_clk);
    read       <= ~wr;
    write      <= wr;
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    if (!wr)
      expq.push_back(exp);
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      chk("waitrequest", 32'h0, 32'h1);
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic settle();
    repeat (3 * DIV) @(posedge ref_clk);
  endtask

  // Read data is taken at the edge where waitrequest is seen low.
  always @(posedge ref_clk)
  begin
    if (read === 1'b1 && waitrequest === 1'b0)
    begin
      if (expq.size() == 0)
        chk("unexpected read", 32'h0, 32'hffff_ffff);
      else
        chk("readdata", expq.pop_front(), readdata);
    end
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end

  initial
  begin
    reset_n = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
    fails = 0;
    tests_run = 0;
    seed = 32'hc655;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    bus(1'b0, 8'h50, 32'h0, 4'hf, 32'h0);
    bus(1'b0, 8'h54, 32'h0, 4'hf, 32'h0);
    bus(1'b0, 8'h58, 32'h0, 4'hf, 32'h0);
    bus(1'b0, 8'h60, 32'h0, 4'hf, 32'h0);
    bus(1'b1, 8'h54, 32'h1, 4'hf, 32'h0);
    bus(1'b0, 8'h54, 32'h0, 4'hf, 32'h1);
    bus(1'b1, 8'h58, 32'h1, 4'hf, 32'h0);
    bus(1'b1, 8'h60, 32'h1, 4'hf, 32'h0);
    bus(1'b0, 8'h50, 32'h0, 4'hf, 32'h11);
    bus(1'b0, 8'h58, 32'h0, 4'hf, 32'h1);
    bus(1'b0, 8'h60, 32'h0, 4'hf, 32'h1);
    settle();
    chk("rtc gate frozen", 32'h0, {31'h0, rtc_clock_gate});
    chk("serial gate frozen", 32'h0, {31'h0, low_energy_serial0_clock_gate});
    bus(1'b1, 8'h54, 32'h0, 4'hf, 32'h0);
    bus(1'b0, 8'h54, 32'h0, 4'hf, 32'h0);
    settle();
    chk("rtc gate released", 32'h1, {31'h0, rtc_clock_gate});
    chk("serial gate released", 32'h1, {31'h0, low_energy_serial0_clock_gate});
    bus(1'b0, 8'h50, 32'h0, 4'hf, 32'h0);
    // Reserved bits stay zero; clearing bit 0 must stop the clock.
    bus(1'b1, 8'h58, 32'h0, 4'hf, 32'h0);
    settle();
    chk("rtc gate stopped", 32'h0, {31'h0, rtc_clock_gate});
    bus(1'b0, 8'h58, 32'h0, 4'hf, 32'h0);
    bus(1'b1, 8'h60, 32'h0, 4'he, 32'h0);
    bus(1'b0, 8'h60, 32'h0, 4'hf, 32'h1);
    bus(1'b1, 8'h50, 32'h11, 4'hf, 32'h0);
    bus(1'b0, 8'h50, 32'h0, 4'hf, 32'h0);
    bus(1'b0, 8'h5c, 32'h0, 4'hf, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      seed = xorshift(seed);
      bus(1'b1, 8'h60, {31'h0, seed[0]}, 4'hf, 32'h0);
      settle();
      chk("serial gate", {31'h0, seed[0]}, {31'h0, low_energy_serial0_clock_gate});
      bus(1'b0, 8'h60, 32'h0, 4'hf, {31'h0, seed[0]});
    end
    repeat (4) @(posedge ref_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
